//--- common/bpm_pkg.sv
/*
  bpm_pkg: register map, field positions, reset values, tick timing and
  carrier types of the buffer pool monitor.
  Assumes a single 125 MHz core clock and a synchronous active-high reset.
*/
package bpm_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_EVT_ENABLE = 8'h00;
	localparam logic [7:0] OFS_HYSTERESIS = 8'h04;
	localparam logic [7:0] OFS_EVT_DATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_CONTROL = 8'h10;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
	localparam logic [7:0] OFS_LOCK_ENABLE = 8'h18;
	localparam logic [7:0] OFS_PKT_WAIT_LIMIT = 8'h1c;
	localparam logic [7:0] OFS_CTL_WAIT_LIMIT = 8'h20;
	localparam logic [7:0] OFS_LAST_PRIM = 8'h24;
	localparam logic [7:0] OFS_LAST_FREE_MAP = 8'h28;
	localparam logic [7:0] OFS_FREEING_MAP = 8'h2c;
	localparam logic [7:0] OFS_QLEN_THR0 = 8'h30;
	localparam logic [7:0] OFS_IDX_LIMIT0 = 8'h44;
	localparam logic [7:0] OFS_QLEN0 = 8'h58;
	localparam int NUM_QUEUES = 5;
	localparam int NUM_POOLS = 16;
	// status bit positions
	localparam int ST_QLEN_LO = 0;
	localparam int ST_IDX_HI = 5;
	localparam int ST_USER_THR = 10;
	localparam int ST_DUP_FREE = 11;
	localparam int STATUS_W = 12;
	// control bit positions
	localparam int CT_OPER = 0;
	localparam int CT_TRAP_SEL = 1;
	localparam int CT_PKT_ESC = 3;
	localparam int CT_CTL_ESC = 4;
	localparam int CT_EVT_IF = 5;
	localparam int CONTROL_W = 6;
	// event enable bit positions
	localparam int EE_GET = 0;
	localparam int EE_FREE = 1;
	localparam int EE_USER_THR = 2;
	localparam int EVT_ENABLE_W = 3;
	// buffer map flag layout
	localparam int FL_VALID = 15;
	localparam int FL_QUEUE = 4;
	// reset values
	localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
	localparam logic [15:0] RESET_THR = 16'h0000;
	localparam logic [15:0] RESET_IDX_LIMIT = 16'hffff;
	localparam logic [11:0] RESET_WAIT_LIMIT = 12'hfff;
	// wait countdown tick
	localparam int CLK_PERIOD_PS = 8000;
	localparam int TICK_PS = 30000;
	localparam int TICK_CYCLES = (TICK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [2:0] TICK_LAST = 3'(TICK_CYCLES - 1);
	// primitive kinds
	typedef enum logic [1:0] {
		BPM_OP_GET = 2'h0,
		BPM_OP_FREE = 2'h1,
		BPM_OP_ENQ = 2'h2,
		BPM_OP_DEQ = 2'h3
	} bpm_op_t;
	// one primitive as seen by the monitor
	typedef struct packed {
		bpm_op_t op;
		logic [3:0] pool;
		logic [2:0] queue;
		logic [15:0] active;
		logic [15:0] user_thr;
		logic [31:0] addr;
	} bpm_prim_t;
	// one buffer map read during a free
	typedef struct packed {
		logic [15:0] flags;
		logic [15:0] index;
		logic [31:0] addr;
	} bpm_map_t;
endpackage

//--- dv/bpm_mem_arb_model.sv
/*
  bpm_mem_arb_model: memory arbiter model that raises the packet and control
  memory requests together and grants them after a slow, fixed hold.
  Assumes go is a one-cycle pulse from the bench in the ref_clk domain.
*/
`timescale 1ns/100ps
module bpm_mem_arb_model #(
	parameter int HOLD = 30
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic go,
	output logic pkt_mem_req,
	output logic ctl_mem_req
);
	logic [7:0] held;
	// requests stay level until the late grant, so escalation has time to show
	always_ff @(posedge ref_clk) begin
		if (srst || (pkt_mem_req && held == 8'(HOLD - 1))) begin
			pkt_mem_req <= 1'b0;
			ctl_mem_req <= 1'b0;
			held <= 8'h00;
		end else if (go) begin
			pkt_mem_req <= 1'b1;
			ctl_mem_req <= 1'b1;
		end else if (pkt_mem_req) begin
			held <= held + 8'h01;
		end
	end
endmodule

//--- dv/bpm_monitor_tb.sv
/*
  bpm_monitor_tb: register, event, free, lock, queue and wait checks of the
  buffer pool monitor.
  Assumes read data stand one cycle after the read strobe.
*/
`timescale 1ns/100ps
module bpm_monitor_tb;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic prim_valid = 1'b0;
	bpm_pkg::bpm_prim_t prim = '0;
	logic map_valid = 1'b0;
	bpm_pkg::bpm_map_t map = '0;
	logic [4:0] queue_inc = 5'h00;
	logic [4:0] queue_dec = 5'h00;
	logic go = 1'b0;
	logic pkt_mem_req, ctl_mem_req, pkt_mem_hi_pri, ctl_mem_hi_pri, event_valid, return_valid;
	logic map_wr_valid, pool_halt, irq, ev;
	logic [31:0] reg_rdata, event_data, map_wr_addr;
	logic [2:0] return_queue;
	logic [3:0] return_pool;
	logic [15:0] return_index, map_wr_flags;
	int num_errors = 0;
	int check_count = 0;
	int act[6] = '{5, 6, 4, 5, 3, 5};
	logic [7:0] radr[7] = '{bpm_pkg::OFS_HYSTERESIS, bpm_pkg::OFS_IDX_LIMIT0, bpm_pkg::OFS_PKT_WAIT_LIMIT,
		bpm_pkg::OFS_CTL_WAIT_LIMIT, bpm_pkg::OFS_STATUS, bpm_pkg::OFS_LAST_PRIM, 8'hfc};
	logic [31:0] rexp[7] = '{32'h0, 32'hffff, 32'hfff, 32'hfff, 32'h0, 32'h0, 32'h0};

	always #4 ref_clk = ~ref_clk;

	bpm_monitor i_dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prim_valid,
		.prim, .map_valid, .map, .queue_inc, .queue_dec, .pkt_mem_req, .ctl_mem_req, .pkt_mem_hi_pri,
		.ctl_mem_hi_pri, .event_valid, .event_data, .return_valid, .return_queue, .return_pool,
		.return_index, .map_wr_valid, .map_wr_addr, .map_wr_flags, .pool_halt, .irq);

	bpm_mem_arb_model i_arb (.ref_clk, .srst, .go, .pkt_mem_req, .ctl_mem_req);

	// one compare, counted, reported only on mismatch
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, "reg_rdata");
	endtask

	// one primitive on pool 2 queue 1 with user threshold 5; ev holds the answer
	task automatic pr(input bpm_pkg::bpm_op_t op, input logic [15:0] cnt, input logic [31:0] a);
		@(posedge ref_clk);
		prim <= '{op: op, pool: 4'h2, queue: 3'h1, active: cnt, user_thr: 16'h0005, addr: a};
		prim_valid <= 1'b1;
		@(posedge ref_clk);
		prim_valid <= 1'b0;
		#1;
		ev = event_valid;
	endtask

	// one buffer map of a free, then its writeback and index return
	task automatic mp(input logic [15:0] fl, input logic [15:0] idx);
		@(posedge ref_clk);
		map <= '{flags: fl, index: idx, addr: 32'h0000_4440};
		map_valid <= 1'b1;
		@(posedge ref_clk);
		map_valid <= 1'b0;
		#1;
		for (int i = 0; i < 6 && map_wr_valid !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk(32'({map_wr_valid, map_wr_flags}), {15'h0, 1'b1, fl & 16'h7fff}, "map_wr_flags");
		chk(map_wr_addr, 32'h0000_4440, "map_wr_addr");
		chk(32'(return_valid), 32'(fl[15]), "return_valid");
		if (fl[15])
			chk({9'h0, return_queue, return_pool, return_index}, {9'h0, fl[6:0], idx}, "return");
	endtask

	task automatic qs(input logic [4:0] i, input logic [4:0] d);
		@(posedge ref_clk);
		queue_inc <= i;
		queue_dec <= d;
		@(posedge ref_clk);
		queue_inc <= 5'h00;
		queue_dec <= 5'h00;
	endtask

	task automatic test_done;
		if (num_errors == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		test_done;
	end

	// main sequence
	initial begin
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		foreach (radr[i])
			rd(radr[i], rexp[i]);
		wr(bpm_pkg::OFS_LAST_FREE_MAP, 32'h1234);
		rd(bpm_pkg::OFS_LAST_FREE_MAP, 32'h0);
		// get and free events each post only while their enable is set
		for (int e = 0; e < 2; e++) begin
			wr(bpm_pkg::OFS_EVT_ENABLE, 32'(1 << e));
			pr(bpm_pkg::BPM_OP_GET, 16'h0001, 32'h100);
			chk(32'(ev), 32'(e == 0), "get event");
			chk(32'({map_wr_valid, map_wr_flags}), 32'h1_8012, "get map flags");
			chk(map_wr_addr, 32'h100, "get map addr");
			pr(bpm_pkg::BPM_OP_FREE, 16'h0001, 32'h200);
			chk(32'(ev), 32'(e == 1), "free event");
			chk(event_data, e ? 32'h200 : 32'h100, "event_data");
		end
		// trap captures only the selected primitive type
		wr(bpm_pkg::OFS_CONTROL, 32'h3);
		pr(bpm_pkg::BPM_OP_GET, 16'h0001, 32'h300);
		pr(bpm_pkg::BPM_OP_FREE, 16'h0001, 32'h400);
		pr(bpm_pkg::BPM_OP_GET, 16'h0001, 32'h500);
		rd(bpm_pkg::OFS_LAST_PRIM, 32'h400);
		// user threshold fires once, re-arms only after falling back by the margin
		wr(bpm_pkg::OFS_EVT_ENABLE, 32'h4);
		wr(bpm_pkg::OFS_HYSTERESIS, 32'h2);
		wr(bpm_pkg::OFS_CONTROL, 32'h20);
		for (int i = 0; i < 6; i++) begin
			pr(6'b010100 >> i & 1 ? bpm_pkg::BPM_OP_FREE : bpm_pkg::BPM_OP_GET, 16'(act[i]), 32'h0);
			chk(32'(ev), 32'(6'b100001 >> i & 1), "threshold event");
		end
		rd(bpm_pkg::OFS_EVT_DATA, 32'h2000_0005);
		rd(bpm_pkg::OFS_STATUS, 32'h400);
		wr(bpm_pkg::OFS_STATUS, 32'hfff);
		wr(bpm_pkg::OFS_EVT_ENABLE, 32'h0);
		wr(bpm_pkg::OFS_CONTROL, 32'h0);
		// freed index at and just over the limit, then a duplicate free
		wr(bpm_pkg::OFS_IDX_LIMIT0, 32'h10);
		for (int j = 0; j < 2; j++) begin
			mp(16'h8003, 16'(16'h10 + j));
			rd(bpm_pkg::OFS_STATUS, 32'(j * 32));
		end
		rd(bpm_pkg::OFS_LAST_FREE_MAP, 32'h4440);
		rd(bpm_pkg::OFS_FREEING_MAP, 32'h8003_0011);
		mp(16'h0003, 16'h0005);
		rd(bpm_pkg::OFS_STATUS, 32'h820);
		// interrupt follows enabled status bits; lock halts primitives
		wr(bpm_pkg::OFS_IRQ_ENABLE, 32'h800);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(32'(irq), 32'h1, "irq");
		wr(bpm_pkg::OFS_IRQ_ENABLE, 32'h1);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(32'(irq), 32'h0, "irq masked");
		wr(bpm_pkg::OFS_LOCK_ENABLE, 32'h20);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(32'(pool_halt), 32'h1, "pool_halt");
		wr(bpm_pkg::OFS_EVT_ENABLE, 32'h1);
		pr(bpm_pkg::BPM_OP_GET, 16'h0001, 32'h600);
		chk(32'(ev), 32'h0, "halted event");
		wr(bpm_pkg::OFS_LOCK_ENABLE, 32'h0);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(32'(pool_halt), 32'h0, "pool_halt off");
		wr(bpm_pkg::OFS_STATUS, 32'hfff);
		rd(bpm_pkg::OFS_STATUS, 32'h0);
		// queue length count and its low threshold, at and above the length
		qs(5'h02, 5'h00);
		qs(5'h02, 5'h00);
		qs(5'h00, 5'h02);
		rd(bpm_pkg::OFS_QLEN0 + 8'h04, 32'h1);
		wr(bpm_pkg::OFS_QLEN_THR0 + 8'h04, 32'h3);
		repeat (3) @(posedge ref_clk);
		rd(bpm_pkg::OFS_STATUS, 32'h2);
		// clearing while the length is still below: the set wins
		wr(bpm_pkg::OFS_STATUS, 32'h2);
		rd(bpm_pkg::OFS_STATUS, 32'h2);
		wr(bpm_pkg::OFS_QLEN_THR0 + 8'h04, 32'h1);
		repeat (3) @(posedge ref_clk);
		wr(bpm_pkg::OFS_STATUS, 32'h2);
		repeat (3) @(posedge ref_clk);
		rd(bpm_pkg::OFS_STATUS, 32'h0);
		// packet request escalates after its countdown, control request does not
		wr(bpm_pkg::OFS_PKT_WAIT_LIMIT, 32'h3);
		wr(bpm_pkg::OFS_CONTROL, 32'h8);
		@(posedge ref_clk);
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (6) @(posedge ref_clk);
		#1;
		chk(32'(pkt_mem_hi_pri), 32'h0, "early hi_pri");
		repeat (12) @(posedge ref_clk);
		#1;
		chk(32'(pkt_mem_hi_pri), 32'h1, "pkt hi_pri");
		chk(32'(ctl_mem_hi_pri), 32'h0, "ctl hi_pri");
		repeat (15) @(posedge ref_clk);
		#1;
		chk(32'(pkt_mem_hi_pri), 32'h0, "granted hi_pri");
		test_done;
	end
endmodule

//--- hw/bpm_monitor.sv
/*
  bpm_monitor: event, threshold, debug capture, error lock and memory wait
  escalation logic of the buffer pool manager.
  Assumes primitives, buffer maps and queue steps arrive as one-cycle strobes
  from the pool datapath, and registers are reached over a plain strobe port.
*/
`timescale 1ns/100ps
// Overview of operation
// [RQ1] matching primitive with its event type enabled posts one event; disabled types post none
// [RQ2] threshold events use a programmable hysteresis margin against repeats
// [RQ3] data word of the latest event is kept readable
// [RQ4] each of five queue lengths below its threshold sets a status bit
// [RQ5] freed index above the queue's index limit sets a status bit
// [RQ6] in operational mode, address of last primitive of selected type is captured
// [RQ7] address of the buffer map read on each free is captured
// [RQ8] set status bit with lock enabled holds pool state machines idle
// [RQ9] enabled memory request loads a countdown with its 12-bit limit
// [RQ10] countdown steps once per 30 ns tick down to zero; the tick here comes every 4 cycles, 32 ns
// [RQ11] countdown at zero with request pending raises request priority
// [RQ12] map of the packet being freed is held; index returns to its queue
// [RQ13] freeing a packet clears the map's valid bit
// [RQ14] get allocation sets the map's valid bit; here a get in the same cycle as a free's writeback is not written back
// [RQ15] interrupt is high while an enabled status bit is set
// [RQ16] queue length counts up on add, down on remove
// [RQ17] pool active count crossing its user threshold issues an event
// [RQ18] threshold re-arms only after count falls back by the hysteresis
module bpm_monitor (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic prim_valid,
	input wire bpm_pkg::bpm_prim_t prim,
	input wire logic map_valid,
	input wire bpm_pkg::bpm_map_t map,
	input wire logic [4:0] queue_inc,
	input wire logic [4:0] queue_dec,
	input wire logic pkt_mem_req,
	input wire logic ctl_mem_req,
	output logic pkt_mem_hi_pri,
	output logic ctl_mem_hi_pri,
	output logic event_valid,
	output logic [31:0] event_data,
	output logic return_valid,
	output logic [2:0] return_queue,
	output logic [3:0] return_pool,
	output logic [15:0] return_index,
	output logic map_wr_valid,
	output logic [31:0] map_wr_addr,
	output logic [15:0] map_wr_flags,
	output logic pool_halt,
	output logic irq
);
	// free sequence states, gray along the path
	typedef enum logic [1:0] {
		BPM_F_IDLE = 2'b00,
		BPM_F_CHECK = 2'b01,
		BPM_F_RETURN = 2'b11
	} bpm_fstate_t;

	logic [bpm_pkg::EVT_ENABLE_W-1:0] evt_enable;
	logic [15:0] hysteresis;
	logic [bpm_pkg::STATUS_W-1:0] status;
	logic [bpm_pkg::CONTROL_W-1:0] control;
	logic [bpm_pkg::STATUS_W-1:0] irq_enable;
	logic [bpm_pkg::STATUS_W-1:0] lock_enable;
	logic [11:0] pkt_wait_limit;
	logic [11:0] ctl_wait_limit;
	logic [31:0] last_prim;
	logic [31:0] last_free_map;
	bpm_pkg::bpm_map_t freeing_map;
	logic [15:0] qlen_thr [bpm_pkg::NUM_QUEUES];
	logic [15:0] idx_limit [bpm_pkg::NUM_QUEUES];
	logic [15:0] qlen [bpm_pkg::NUM_QUEUES];
	logic [4:0] qlen_below;
	logic [bpm_pkg::NUM_POOLS-1:0] thr_armed;
	bpm_fstate_t fstate;
	bpm_fstate_t next_fstate;
	logic [2:0] tick_cnt;
	logic tick;

	// register decode
	wire logic [2:0] thr_sel = 3'((reg_addr - bpm_pkg::OFS_QLEN_THR0) >> 2);
	wire logic [2:0] lim_sel = 3'((reg_addr - bpm_pkg::OFS_IDX_LIMIT0) >> 2);
	wire logic [2:0] len_sel = 3'((reg_addr - bpm_pkg::OFS_QLEN0) >> 2);
	wire logic in_thr = reg_addr >= bpm_pkg::OFS_QLEN_THR0 && reg_addr < bpm_pkg::OFS_IDX_LIMIT0;
	wire logic in_lim = reg_addr >= bpm_pkg::OFS_IDX_LIMIT0 && reg_addr < bpm_pkg::OFS_QLEN0;
	wire logic in_len = reg_addr >= bpm_pkg::OFS_QLEN0 && reg_addr < bpm_pkg::OFS_QLEN0 + 8'h14;
	wire logic wr_status = reg_wr && reg_addr == bpm_pkg::OFS_STATUS;

	// halt and primitive acceptance
	wire logic locked = |(status & lock_enable); // RQ8
	wire logic prim_go = prim_valid && !pool_halt;
	wire logic is_get = prim_go && prim.op == bpm_pkg::BPM_OP_GET;
	wire logic is_free = prim_go && prim.op == bpm_pkg::BPM_OP_FREE;

	// user threshold crossing with hysteresis, armed per pool
	wire logic evt_if_on = control[bpm_pkg::CT_EVT_IF];
	wire logic pool_armed = thr_armed[prim.pool];
	wire logic [16:0] rearm_sum = {1'b0, prim.active} + {1'b0, hysteresis};
	wire logic thr_cross = (is_get || is_free) && pool_armed && prim.active >= prim.user_thr; // RQ17
	wire logic thr_rearm = (is_get || is_free) && !pool_armed && rearm_sum <= {1'b0, prim.user_thr}; // RQ18
	wire logic thr_event = thr_cross && evt_if_on && evt_enable[bpm_pkg::EE_USER_THR]; // RQ2

	// event type matching
	wire logic get_event = is_get && evt_enable[bpm_pkg::EE_GET]; // RQ1
	wire logic free_event = is_free && evt_enable[bpm_pkg::EE_FREE]; // RQ1
	wire logic any_event = get_event || free_event || thr_event;
	wire logic [31:0] next_event_data = thr_event ? {prim.pool, 12'h000, prim.active} : prim.addr;

	// free sequence checks
	wire logic map_in = fstate == BPM_F_IDLE && map_valid && !pool_halt;
	wire logic [2:0] map_queue = freeing_map.flags[bpm_pkg::FL_QUEUE +: 3];
	// queue fields beyond the last queue never index the limit table
	wire logic idx_over = fstate == BPM_F_CHECK && map_queue < 3'(bpm_pkg::NUM_QUEUES)
		&& freeing_map.index > idx_limit[map_queue]; // RQ5
	wire logic dup_free = fstate == BPM_F_CHECK && !freeing_map.flags[bpm_pkg::FL_VALID];
	wire logic trap_hit = prim_go && control[bpm_pkg::CT_OPER] && prim.op == control[bpm_pkg::CT_TRAP_SEL +: 2];

	// status events, set wins over a clearing write
	logic [bpm_pkg::STATUS_W-1:0] status_set;
	logic [bpm_pkg::STATUS_W-1:0] next_status;
	logic [4:0] idx_set;
	assign idx_set = idx_over ? 5'(5'h01 << map_queue) : 5'h00;
	assign status_set = {dup_free, thr_cross && evt_if_on, idx_set, qlen_below};
	assign next_status = (wr_status ? status & ~reg_wdata[bpm_pkg::STATUS_W-1:0] : status) | status_set;

	// free sequence transitions; a lock parks the machine in idle
	always_comb begin
		next_fstate = fstate;
		case (fstate)
			BPM_F_IDLE: begin
				if (map_in) begin
					next_fstate = BPM_F_CHECK;
				end
			end
			BPM_F_CHECK: next_fstate = BPM_F_RETURN;
			BPM_F_RETURN: next_fstate = BPM_F_IDLE;
			default: next_fstate = BPM_F_IDLE;
		endcase
		if (locked) begin
			next_fstate = BPM_F_IDLE; // RQ8
		end
	end

	// read data selection
	function automatic logic [31:0] read_mux(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			bpm_pkg::OFS_EVT_ENABLE: v = 32'(evt_enable);
			bpm_pkg::OFS_HYSTERESIS: v = 32'(hysteresis);
			bpm_pkg::OFS_EVT_DATA: v = event_data; // RQ3
			bpm_pkg::OFS_STATUS: v = 32'(status);
			bpm_pkg::OFS_CONTROL: v = 32'(control);
			bpm_pkg::OFS_IRQ_ENABLE: v = 32'(irq_enable);
			bpm_pkg::OFS_LOCK_ENABLE: v = 32'(lock_enable);
			bpm_pkg::OFS_PKT_WAIT_LIMIT: v = 32'(pkt_wait_limit);
			bpm_pkg::OFS_CTL_WAIT_LIMIT: v = 32'(ctl_wait_limit);
			bpm_pkg::OFS_LAST_PRIM: v = last_prim;
			bpm_pkg::OFS_LAST_FREE_MAP: v = last_free_map;
			bpm_pkg::OFS_FREEING_MAP: v = {freeing_map.flags, freeing_map.index};
			default: begin
				if (in_thr && a[1:0] == 2'b00) begin
					v = 32'(qlen_thr[thr_sel]);
				end else if (in_lim && a[1:0] == 2'b00) begin
					v = 32'(idx_limit[lim_sel]);
				end else if (in_len && a[1:0] == 2'b00) begin
					v = 32'(qlen[len_sel]);
				end
			end
		endcase
		return v;
	endfunction

	// 32 ns tick divider, 4 cycles of 8 ns
	assign tick = tick_cnt == bpm_pkg::TICK_LAST;
	always_ff @(posedge ref_clk) begin
		if (srst || tick) begin
			tick_cnt <= 3'h0;
		end else begin
			tick_cnt <= tick_cnt + 3'h1; // RQ10
		end
	end

	// software writable registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			evt_enable <= '0;
			hysteresis <= bpm_pkg::RESET_THR;
			control <= '0;
			irq_enable <= '0;
			lock_enable <= '0;
			pkt_wait_limit <= bpm_pkg::RESET_WAIT_LIMIT;
			ctl_wait_limit <= bpm_pkg::RESET_WAIT_LIMIT;
			for (int i = 0; i < bpm_pkg::NUM_QUEUES; i++) begin
				qlen_thr[i] <= bpm_pkg::RESET_THR;
				idx_limit[i] <= bpm_pkg::RESET_IDX_LIMIT;
			end
		end else if (reg_wr) begin
			case (reg_addr)
				bpm_pkg::OFS_EVT_ENABLE: evt_enable <= reg_wdata[bpm_pkg::EVT_ENABLE_W-1:0];
				bpm_pkg::OFS_HYSTERESIS: hysteresis <= reg_wdata[15:0];
				bpm_pkg::OFS_CONTROL: control <= reg_wdata[bpm_pkg::CONTROL_W-1:0];
				bpm_pkg::OFS_IRQ_ENABLE: irq_enable <= reg_wdata[bpm_pkg::STATUS_W-1:0];
				bpm_pkg::OFS_LOCK_ENABLE: lock_enable <= reg_wdata[bpm_pkg::STATUS_W-1:0];
				bpm_pkg::OFS_PKT_WAIT_LIMIT: pkt_wait_limit <= reg_wdata[11:0];
				bpm_pkg::OFS_CTL_WAIT_LIMIT: ctl_wait_limit <= reg_wdata[11:0];
				default: begin
					if (in_thr && reg_addr[1:0] == 2'b00) begin
						qlen_thr[thr_sel] <= reg_wdata[15:0];
					end else if (in_lim && reg_addr[1:0] == 2'b00) begin
						idx_limit[lim_sel] <= reg_wdata[15:0];
					end
				end
			endcase
		end
	end

	// status, interrupt, halt and read port
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			status <= '0;
			irq <= 1'b0;
			pool_halt <= 1'b0;
			reg_rdata <= bpm_pkg::RESET_ZERO;
		end else begin
			status <= next_status; // RQ4
			irq <= |(next_status & irq_enable); // RQ15
			pool_halt <= |(next_status & lock_enable); // RQ8
			reg_rdata <= reg_rd ? read_mux(reg_addr) : bpm_pkg::RESET_ZERO;
		end
	end

	// events, hysteresis arming and debug capture
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			event_valid <= 1'b0;
			event_data <= bpm_pkg::RESET_ZERO;
			thr_armed <= '1;
			last_prim <= bpm_pkg::RESET_ZERO;
		end else begin
			event_valid <= any_event; // RQ1
			if (any_event) begin
				event_data <= next_event_data; // RQ3
			end
			if (thr_cross) begin
				thr_armed[prim.pool] <= 1'b0; // RQ2
			end else if (thr_rearm) begin
				thr_armed[prim.pool] <= 1'b1; // RQ18
			end
			if (trap_hit) begin
				last_prim <= prim.addr; // RQ6
			end
		end
	end

	// free sequence and map writeback
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			fstate <= BPM_F_IDLE;
			freeing_map <= '0;
			last_free_map <= bpm_pkg::RESET_ZERO;
			return_valid <= 1'b0;
			return_queue <= 3'h0;
			return_pool <= 4'h0;
			return_index <= 16'h0000;
			map_wr_valid <= 1'b0;
			map_wr_addr <= bpm_pkg::RESET_ZERO;
			map_wr_flags <= 16'h0000;
		end else begin
			fstate <= next_fstate;
			return_valid <= 1'b0;
			map_wr_valid <= 1'b0;
			if (map_in) begin
				freeing_map <= map; // RQ12
				last_free_map <= map.addr; // RQ7
			end
			if (fstate == BPM_F_RETURN && !locked) begin
				return_valid <= freeing_map.flags[bpm_pkg::FL_VALID]; // RQ12
				return_queue <= map_queue;
				return_pool <= freeing_map.flags[3:0];
				return_index <= freeing_map.index;
				map_wr_valid <= 1'b1;
				map_wr_addr <= freeing_map.addr;
				map_wr_flags <= freeing_map.flags & ~(16'h0001 << bpm_pkg::FL_VALID); // RQ13
			end else if (is_get) begin
				map_wr_valid <= 1'b1;
				map_wr_addr <= prim.addr;
				map_wr_flags <= {1'b1, 8'h00, prim.queue, prim.pool}; // RQ14
			end
		end
	end

	// queue length counters
	for (genvar q = 0; q < bpm_pkg::NUM_QUEUES; q++) begin : g_queue
		bpm_queue_len u_len (
			.ref_clk(ref_clk),
			.srst(srst),
			.inc(queue_inc[q]),
			.dec(queue_dec[q]),
			.thr(qlen_thr[q]),
			.len(qlen[q]),
			.below(qlen_below[q])
		);
	end

	// memory wait escalation for packet and control memory
	bpm_wait_timer u_pkt_wait (
		.ref_clk(ref_clk),
		.srst(srst),
		.tick(tick),
		.enable(control[bpm_pkg::CT_PKT_ESC]),
		.req(pkt_mem_req),
		.limit(pkt_wait_limit),
		.hi_pri(pkt_mem_hi_pri)
	);
	bpm_wait_timer u_ctl_wait (
		.ref_clk(ref_clk),
		.srst(srst),
		.tick(tick),
		.enable(control[bpm_pkg::CT_CTL_ESC]),
		.req(ctl_mem_req),
		.limit(ctl_wait_limit),
		.hi_pri(ctl_mem_hi_pri)
	);

	// free sequence steps
	sequence free_start_s;
		fstate == BPM_F_IDLE && map_valid && !pool_halt && !locked;
	endsequence
	sequence free_walk_s;
		##1 fstate == BPM_F_CHECK ##1 fstate == BPM_F_RETURN;
	endsequence

	free_walk_a: assert property (@(posedge ref_clk) disable iff (srst || locked) // RQ12
		free_start_s |-> free_walk_s)
		else $error("free sequence did not walk check then return");
	event_gate_a: assert property (@(posedge ref_clk) disable iff (srst) // RQ1
		event_valid |-> $past(prim_valid) && ($past(prim.op) == bpm_pkg::BPM_OP_GET
			|| $past(prim.op) == bpm_pkg::BPM_OP_FREE) && $past(evt_enable) != '0)
		else $error("event posted without an enabled matching primitive");
	event_copy_a: assert property (@(posedge ref_clk) disable iff (srst) // RQ3
		event_valid |=> event_data == $past(event_data) || event_valid)
		else $error("event data changed without a new event");
	irq_level_a: assert property (@(posedge ref_clk) disable iff (srst) // RQ15
		irq == |(status & $past(irq_enable)))
		else $error("interrupt does not follow enabled status");
	lock_idle_a: assert property (@(posedge ref_clk) disable iff (srst) // RQ8
		pool_halt |-> ##1 fstate == BPM_F_IDLE)
		else $error("free sequence running while locked");
	clear_valid_a: assert property (@(posedge ref_clk) disable iff (srst) // RQ13
		$rose(return_valid) |-> map_wr_valid && !map_wr_flags[bpm_pkg::FL_VALID])
		else $error("freed map kept its valid bit");
	set_wins_a: assert property (@(posedge ref_clk) disable iff (srst) // RQ4
		(wr_status && status_set != '0) |=> (status & $past(status_set)) == $past(status_set))
		else $error("clearing write lost a status event");
	rearm_hyst_a: assert property (@(posedge ref_clk) disable iff (srst) // RQ18
		(thr_cross ##1 !prim_go ##1 (is_get || is_free) && prim.pool == $past(prim.pool, 2)
			&& rearm_sum > {1'b0, prim.user_thr}) |=> !thr_armed[$past(prim.pool)])
		else $error("threshold re-armed inside the hysteresis band");
endmodule

//--- hw/bpm_queue_len.sv
/*
  bpm_queue_len: length counter of one pointer queue and its low threshold flag.
  Assumes inc and dec are one-cycle pulses from the pool datapath.
*/
`timescale 1ns/100ps
module bpm_queue_len (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic inc,
	input wire logic dec,
	input wire logic [15:0] thr,
	output logic [15:0] len,
	output logic below
);
	logic [15:0] next_len;

	// add and remove in one cycle cancel out
	assign next_len = (inc && !dec) ? len + 16'h0001 : (dec && !inc) ? len - 16'h0001 : len;

	// count and compare
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			len <= 16'h0000;
			below <= 1'b0;
		end else begin
			len <= next_len; // RQ16
			below <= next_len < thr; // RQ4
		end
	end

	qlen_step_a: assert property (@(posedge ref_clk) disable iff (srst) // RQ16
		(inc && !dec) |=> len == $past(len) + 16'h0001)
		else $error("queue length did not step up");
endmodule

//--- hw/bpm_wait_timer.sv
/*
  bpm_wait_timer: countdown that escalates a long-held memory request.
  Assumes req is held until the arbiter grants it and tick pulses every 32 ns.
*/
`timescale 1ns/100ps
module bpm_wait_timer (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic tick,
	input wire logic enable,
	input wire logic req,
	input wire logic [11:0] limit,
	output logic hi_pri
);
	logic req_q;
	logic armed;
	logic [11:0] count;
	wire logic start = enable && req && !req_q;

	// load on a new request, count down per tick, stop at zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			req_q <= 1'b0;
			armed <= 1'b0;
			count <= 12'h000;
			hi_pri <= 1'b0;
		end else begin
			req_q <= req;
			if (start) begin
				count <= limit; // RQ9
				armed <= 1'b1;
			end else if (!req) begin
				armed <= 1'b0;
			end else if (tick && count != 12'h000) begin
				count <= count - 12'h001; // RQ10
			end
			hi_pri <= req && armed && !start && count == 12'h000; // RQ11
		end
	end

	escalate_a: assert property (@(posedge ref_clk) disable iff (srst) // RQ11
		hi_pri |-> $past(req) && $past(count) == 12'h000)
		else $error("escalation without an expired count");
endmodule
